/* design/clk_ctrl_consts.svh */
// Offsets, field positions, reset values and decode constants of the
// high-frequency clock control block.
// Assumes inclusion by bare name from the design directory.
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CLK_OFF_CRYSTAL        8'h04
`define CLK_OFF_LOOP_CFG       8'h08
`define CLK_OFF_FINAL_DIV      8'h0c
`define CLK_OFF_SLOW_RING      8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CLK_BIT_ENABLE         30
`define CLK_BIT_READY          31
`define CLK_LSB_REF_DIV        0
`define CLK_MSB_REF_DIV        2
`define CLK_LSB_VCO_MULT       4
`define CLK_MSB_VCO_MULT       9
`define CLK_LSB_OUT_DIV        10
`define CLK_MSB_OUT_DIV        11
`define CLK_BIT_HF_SEL         16
`define CLK_BIT_REF_SEL        17
`define CLK_BIT_BYPASS         18
`define CLK_BIT_LOCK           31
`define CLK_LSB_FINAL_DIV      0
`define CLK_MSB_FINAL_DIV      5
`define CLK_BIT_FINAL_BYPASS   8
`define CLK_LSB_SLOW_DIV       0
`define CLK_MSB_SLOW_DIV       5
`define CLK_LSB_SLOW_TRIM      16
`define CLK_MSB_SLOW_TRIM      20

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CLK_RST_CRYSTAL_EN     1'h1
`define CLK_RST_REF_DIV        3'h1
`define CLK_RST_VCO_MULT       6'h1f
`define CLK_RST_OUT_DIV        2'h3
`define CLK_RST_HF_SEL         1'h0
`define CLK_RST_REF_SEL        1'h1
`define CLK_RST_BYPASS         1'h1
`define CLK_RST_FINAL_DIV      6'h00
`define CLK_RST_FINAL_BYPASS   1'h1
`define CLK_RST_SLOW_DIV       6'h04
`define CLK_RST_SLOW_TRIM      5'h10
`define CLK_RST_SLOW_EN        1'h1

// ----------------------------------------------------------------------
// Decoded ratios after reset
// ----------------------------------------------------------------------
`define CLK_RST_REF_RATIO      3'h2
`define CLK_RST_MULT_RATIO     8'h40
`define CLK_RST_OUT_RATIO      4'h8
`define CLK_RST_FINAL_RATIO    8'h01

`endif

/* design/clk_ctrl_pkg.sv */
// Types shared by the high-frequency clock control block and its users.
// Assumes the constants header is on the include path.
package clk_ctrl_pkg;

    // ------------------------------------------------------------------
    // Bus carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    // ------------------------------------------------------------------
    // Analog side
    // ------------------------------------------------------------------
    typedef struct packed {
        logic crystal_osc_ready;
        logic pll_lock;
        logic slow_ring_osc_ready;
    } osc_status_s;

    typedef struct packed {
        logic [2:0] ref_div;
        logic [5:0] vco_mult;
        logic [1:0] out_div;
        logic       bypass;
        logic [5:0] final_div;
        logic       final_divide_bypass;
    } loop_ctrl_s;

    typedef struct packed {
        logic [5:0] div;
        logic [4:0] trim;
        logic       en;
    } slow_osc_ctrl_s;

    typedef struct packed {
        logic [2:0] ref_ratio;
        logic [7:0] mult_ratio;
        logic [3:0] out_ratio;
        logic       out_code_bad;
        logic [7:0] final_ratio;
        logic       hf_from_crystal;
    } ratio_s;

    typedef enum logic [1:0] {
        HF_SRC_FAST_RING = 2'b01,
        HF_SRC_PLL       = 2'b10
    } hf_src_e;

    typedef enum logic [1:0] {
        REF_FAST_RING = 2'b01,
        REF_CRYSTAL   = 2'b10
    } pll_ref_e;

endpackage : clk_ctrl_pkg

/* design/hf_clock_pll_and_slow_osc_control.sv */
// Register file and control logic of the high-frequency clock path:
// crystal oscillator, PLL setup, PLL final divider and slow ring oscillator.
// Assumes a classic Wishbone master on i_clock, analog status flags that
// arrive asynchronously, and a wakeup reset pulse from same-clock logic.
`timescale 1ns/1ps
`include "clk_ctrl_consts.svh"

module hf_clock_pll_and_slow_osc_control (
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    input  wire logic                        i_wakeup_rst,
    input  wire clk_ctrl_pkg::wb_req_s       i_wb_req,
    output logic                             o_wb_ack,
    output logic [31:0]                      o_wb_dat,
    input  wire clk_ctrl_pkg::osc_status_s   i_osc_status,
    output logic                             o_crystal_osc_en,
    output clk_ctrl_pkg::loop_ctrl_s         o_loop_ctrl,
    output clk_ctrl_pkg::pll_ref_e           o_pll_ref,
    output clk_ctrl_pkg::hf_src_e            o_hf_src,
    output clk_ctrl_pkg::slow_osc_ctrl_s     o_slow_osc_ctrl,
    output clk_ctrl_pkg::ratio_s             o_ratio
);
    import clk_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic           ack_reg;
    logic [31:0]    rdata_reg;
    logic [31:0]    rdata_next;
    logic [31:0]    wmask;
    logic [31:0]    wdata;
    logic           access;
    logic           wr_crystal;
    logic           wr_loop;
    logic           wr_final;
    logic           wr_slow;
    logic [2:0]     meta_reg;
    logic [2:0]     sync_reg;
    logic           crystal_en_reg;
    logic [2:0]     ref_div_reg;
    logic [5:0]     vco_mult_reg;
    logic [1:0]     out_div_reg;
    logic           hf_sel_reg;
    logic           ref_sel_reg;
    logic           bypass_reg;
    logic [5:0]     final_div_reg;
    logic           final_bypass_reg;
    logic [5:0]     slow_div_reg;
    logic [4:0]     slow_trim_reg;
    logic           slow_en_reg;
    pll_ref_e       pll_ref_reg;
    hf_src_e        hf_src_reg;
    ratio_s         ratio_reg;
    ratio_s         ratio_next;
    logic           crystal_rdy;
    logic           pll_lock;
    logic           slow_rdy;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Byte lanes: each sel bit opens eight data bits
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
            assign wmask[gb*8 +: 8] = {8{i_wb_req.sel[gb]}};
        end
    endgenerate

    assign access     = i_wb_req.cyc & i_wb_req.stb & ~ack_reg;
    assign wdata      = i_wb_req.dat & wmask;
    assign wr_crystal = access & i_wb_req.we
                        & (i_wb_req.adr == `CLK_OFF_CRYSTAL);
    assign wr_loop    = access & i_wb_req.we
                        & (i_wb_req.adr == `CLK_OFF_LOOP_CFG);
    assign wr_final   = access & i_wb_req.we
                        & (i_wb_req.adr == `CLK_OFF_FINAL_DIV);
    assign wr_slow    = access & i_wb_req.we
                        & (i_wb_req.adr == `CLK_OFF_SLOW_RING);

    // Every access is answered one cycle later, mapped or not
    // A strobe held into the ack cycle is not taken a second time
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'h0;
        end else begin
            ack_reg <= access;
        end
    end

    // ------------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------------
    // Flags come from free-running analog parts, so two flops first
    // Two-stage flag sync
    genvar gs;
    generate
        for (gs = 0; gs < 3; gs = gs + 1) begin : g_sync
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    meta_reg[gs] <= 1'h0;
                    sync_reg[gs] <= 1'h0;
                end else begin
                    meta_reg[gs] <= i_osc_status[gs];
                    sync_reg[gs] <= meta_reg[gs];
                end
            end
        end
    endgenerate

    // Struct order: crystal ready, lock, slow ready (msb first)
    assign slow_rdy    = sync_reg[0];
    assign pll_lock    = sync_reg[1];
    assign crystal_rdy = sync_reg[2];

    // ------------------------------------------------------------------
    // Crystal oscillator
    // ------------------------------------------------------------------
    // Only lane 3 reaches the enable; other lanes leave it alone
    // Enable set at wakeup, software clears
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            crystal_en_reg <= `CLK_RST_CRYSTAL_EN;
        end else if (i_wakeup_rst) begin
            crystal_en_reg <= `CLK_RST_CRYSTAL_EN;
        end else if (wr_crystal & i_wb_req.sel[3]) begin
            crystal_en_reg <= wdata[`CLK_BIT_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // PLL configuration
    // ------------------------------------------------------------------
    // Wakeup beats a write in the same cycle; the write is lost
    // Ratio fields writable in bypass
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ref_div_reg  <= `CLK_RST_REF_DIV;
            vco_mult_reg <= `CLK_RST_VCO_MULT;
            out_div_reg  <= `CLK_RST_OUT_DIV;
        end else if (i_wakeup_rst) begin
            ref_div_reg  <= `CLK_RST_REF_DIV;
            vco_mult_reg <= `CLK_RST_VCO_MULT;
            out_div_reg  <= `CLK_RST_OUT_DIV;
        end else if (wr_loop) begin
            ref_div_reg  <= (ref_div_reg & ~wmask[2:0])
                            | wdata[`CLK_MSB_REF_DIV:`CLK_LSB_REF_DIV];
            vco_mult_reg <= (vco_mult_reg & ~wmask[9:4])
                            | wdata[`CLK_MSB_VCO_MULT:`CLK_LSB_VCO_MULT];
            out_div_reg  <= (out_div_reg & ~wmask[11:10])
                            | wdata[`CLK_MSB_OUT_DIV:`CLK_LSB_OUT_DIV];
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            hf_sel_reg  <= `CLK_RST_HF_SEL;
            ref_sel_reg <= `CLK_RST_REF_SEL;
            bypass_reg  <= `CLK_RST_BYPASS;
        end else if (i_wakeup_rst) begin
            hf_sel_reg  <= `CLK_RST_HF_SEL;
            ref_sel_reg <= `CLK_RST_REF_SEL;
            bypass_reg  <= `CLK_RST_BYPASS;
        end else if (wr_loop & i_wb_req.sel[2]) begin
            hf_sel_reg  <= wdata[`CLK_BIT_HF_SEL];
            ref_sel_reg <= wdata[`CLK_BIT_REF_SEL];
            bypass_reg  <= wdata[`CLK_BIT_BYPASS];
        end
    end

    // Clock steering follows the stored bits one cycle later
    // Bypass routes selected reference
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pll_ref_reg <= REF_CRYSTAL;
            hf_src_reg  <= HF_SRC_FAST_RING;
        end else begin
            pll_ref_reg <= ref_sel_reg ? REF_CRYSTAL : REF_FAST_RING;
            hf_src_reg  <= hf_sel_reg ? HF_SRC_PLL : HF_SRC_FAST_RING;
        end
    end

    // ------------------------------------------------------------------
    // PLL final divider
    // ------------------------------------------------------------------
    // Only bit 8 of the bypass field is stored; the rest read as zero
    // Divide-by-1 after reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            final_div_reg    <= `CLK_RST_FINAL_DIV;
            final_bypass_reg <= `CLK_RST_FINAL_BYPASS;
        end else if (i_wakeup_rst) begin
            final_div_reg    <= `CLK_RST_FINAL_DIV;
            final_bypass_reg <= `CLK_RST_FINAL_BYPASS;
        end else if (wr_final) begin
            final_div_reg    <= (final_div_reg & ~wmask[5:0])
                                | wdata[`CLK_MSB_FINAL_DIV:`CLK_LSB_FINAL_DIV];
            if (i_wb_req.sel[1]) begin
                final_bypass_reg <= wdata[`CLK_BIT_FINAL_BYPASS];
            end
        end
    end

    // ------------------------------------------------------------------
    // Slow ring oscillator
    // ------------------------------------------------------------------
    // Only power-on reset touches it: it lives in the always-on domain
    // Middle tap, divide by five
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            slow_div_reg  <= `CLK_RST_SLOW_DIV;
            slow_trim_reg <= `CLK_RST_SLOW_TRIM;
            slow_en_reg   <= `CLK_RST_SLOW_EN;
        end else if (wr_slow) begin
            slow_div_reg  <= (slow_div_reg & ~wmask[5:0])
                             | wdata[`CLK_MSB_SLOW_DIV:`CLK_LSB_SLOW_DIV];
            slow_trim_reg <= (slow_trim_reg & ~wmask[20:16])
                             | wdata[`CLK_MSB_SLOW_TRIM:`CLK_LSB_SLOW_TRIM];
            if (i_wb_req.sel[3]) begin
                slow_en_reg <= wdata[`CLK_BIT_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------------
    // Ratio decode
    // ------------------------------------------------------------------
    // Ratios are registered, so they lag the fields by one cycle
    always_comb begin
        ratio_next = '0;
        ratio_next.ref_ratio  = {1'h0, ref_div_reg[1:0]} + 3'h1;
        ratio_next.mult_ratio = {1'h0, vco_mult_reg, 1'h0} + 8'h02;
        unique case (out_div_reg)
            2'h1: ratio_next.out_ratio = 4'h2;
            2'h2: ratio_next.out_ratio = 4'h4;
            2'h3: ratio_next.out_ratio = 4'h8;
            // Code zero is kept as written and only flagged
            2'h0: begin
                ratio_next.out_ratio    = 4'h0;
                ratio_next.out_code_bad = 1'h1;
            end
        endcase
        if (final_bypass_reg) begin
            ratio_next.final_ratio = 8'h01;
        end else begin
            ratio_next.final_ratio = {1'h0, final_div_reg, 1'h0} + 8'h02;
        end
        ratio_next.hf_from_crystal = hf_sel_reg & bypass_reg & ref_sel_reg;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ratio_reg                 <= '0;
            ratio_reg.ref_ratio       <= `CLK_RST_REF_RATIO;
            ratio_reg.mult_ratio      <= `CLK_RST_MULT_RATIO;
            ratio_reg.out_ratio       <= `CLK_RST_OUT_RATIO;
            ratio_reg.final_ratio     <= `CLK_RST_FINAL_RATIO;
        end else begin
            ratio_reg <= ratio_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        // Reserved bits and unmapped offsets read as zero
        rdata_next = 32'h0000_0000;
        unique case (i_wb_req.adr)
            `CLK_OFF_CRYSTAL: begin
                rdata_next[`CLK_BIT_READY]  = crystal_rdy;
                rdata_next[`CLK_BIT_ENABLE] = crystal_en_reg;
            end
            `CLK_OFF_LOOP_CFG: begin
                rdata_next[`CLK_MSB_REF_DIV:`CLK_LSB_REF_DIV]   = ref_div_reg;
                rdata_next[`CLK_MSB_VCO_MULT:`CLK_LSB_VCO_MULT] = vco_mult_reg;
                rdata_next[`CLK_MSB_OUT_DIV:`CLK_LSB_OUT_DIV]   = out_div_reg;
                rdata_next[`CLK_BIT_HF_SEL]  = hf_sel_reg;
                rdata_next[`CLK_BIT_REF_SEL] = ref_sel_reg;
                rdata_next[`CLK_BIT_BYPASS]  = bypass_reg;
                rdata_next[`CLK_BIT_LOCK]    = pll_lock;
            end
            `CLK_OFF_FINAL_DIV: begin
                rdata_next[`CLK_MSB_FINAL_DIV:`CLK_LSB_FINAL_DIV] =
                    final_div_reg;
                rdata_next[`CLK_BIT_FINAL_BYPASS] = final_bypass_reg;
            end
            `CLK_OFF_SLOW_RING: begin
                rdata_next[`CLK_MSB_SLOW_DIV:`CLK_LSB_SLOW_DIV]   =
                    slow_div_reg;
                rdata_next[`CLK_MSB_SLOW_TRIM:`CLK_LSB_SLOW_TRIM] =
                    slow_trim_reg;
                rdata_next[`CLK_BIT_ENABLE] = slow_en_reg;
                rdata_next[`CLK_BIT_READY]  = slow_rdy;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Data is latched with ack so it stands while ack is high
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (access) begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Each output is a register or a field of one
    assign o_wb_ack                        = ack_reg;
    assign o_wb_dat                        = rdata_reg;
    assign o_crystal_osc_en                = crystal_en_reg;
    assign o_loop_ctrl.ref_div             = ref_div_reg;
    assign o_loop_ctrl.vco_mult            = vco_mult_reg;
    assign o_loop_ctrl.out_div             = out_div_reg;
    assign o_loop_ctrl.bypass              = bypass_reg;
    assign o_loop_ctrl.final_div           = final_div_reg;
    assign o_loop_ctrl.final_divide_bypass = final_bypass_reg;
    assign o_pll_ref                       = pll_ref_reg;
    assign o_hf_src                        = hf_src_reg;
    assign o_slow_osc_ctrl.div             = slow_div_reg;
    assign o_slow_osc_ctrl.trim            = slow_trim_reg;
    assign o_slow_osc_ctrl.en              = slow_en_reg;
    assign o_ratio                         = ratio_reg;

endmodule : hf_clock_pll_and_slow_osc_control

/* dv/hf_clock_pll_and_slow_osc_control_chk.sv */
// Assertion checker for the clock control block, bound to its top module.
// Assumes one clock domain with i_rst as the asynchronous reset.
`timescale 1ns/1ps
module clk_ctrl_chk
    import clk_ctrl_pkg::*;
(
    input wire logic           i_clock,
    input wire logic           i_rst,
    input wire logic           i_wakeup_rst,
    input wire wb_req_s        i_wb_req,
    input wire logic           o_wb_ack,
    input wire logic [31:0]    o_wb_dat,
    input wire osc_status_s    i_osc_status,
    input wire logic           o_crystal_osc_en,
    input wire loop_ctrl_s     o_loop_ctrl,
    input wire pll_ref_e       o_pll_ref,
    input wire hf_src_e        o_hf_src,
    input wire slow_osc_ctrl_s o_slow_osc_ctrl,
    input wire ratio_s         o_ratio
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // A wakeup in the same cycle wins over the write, so it is excluded
    wire wr = i_wb_req.cyc & i_wb_req.stb & ~o_wb_ack & i_wb_req.we
              & ~i_wakeup_rst;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_xen;
        wr && i_wb_req.adr == 8'h04 && i_wb_req.sel[3]
        |=> o_crystal_osc_en == $past(i_wb_req.dat[30]);
    endproperty
    a_xen: assert property (p_xen) else $error("crystal enable");
    property p_refw;
        wr && i_wb_req.adr == 8'h08 && i_wb_req.sel[0]
        |=> o_wb_ack && o_loop_ctrl.ref_div == $past(i_wb_req.dat[2:0]);
    endproperty
    a_refw: assert property (p_refw) else $error("ref write");
    property p_refr;
        o_ratio.ref_ratio == $past(o_loop_ctrl.ref_div[1:0]) + 3'h1;
    endproperty
    a_refr: assert property (p_refr) else $error("ref ratio");
    property p_mul;
        o_ratio.mult_ratio == {1'b0, $past(o_loop_ctrl.vco_mult), 1'b0}
                              + 8'h02;
    endproperty
    a_mul: assert property (p_mul) else $error("mult ratio");
    property p_out;
        $past(o_loop_ctrl.out_div) == 2'h0 ? o_ratio.out_code_bad
        : o_ratio.out_ratio == 4'h1 << $past(o_loop_ctrl.out_div);
    endproperty
    a_out: assert property (p_out) else $error("out ratio");
    property p_fin;
        o_ratio.final_ratio == ($past(o_loop_ctrl.final_divide_bypass)
            ? 8'h01 : {1'b0, $past(o_loop_ctrl.final_div), 1'b0} + 8'h02);
    endproperty
    a_fin: assert property (p_fin) else $error("final ratio");
    property p_wake;
        i_wakeup_rst |=> o_loop_ctrl.bypass && o_crystal_osc_en
            && o_loop_ctrl.final_divide_bypass ##1 o_hf_src == HF_SRC_FAST_RING;
    endproperty
    a_wake: assert property (p_wake) else $error("wakeup values");
    property p_slow;
        i_wakeup_rst && !i_wb_req.stb |=> $stable(o_slow_osc_ctrl);
    endproperty
    a_slow: assert property (p_slow) else $error("slow ring kept");
    c_wr: cover property (wr);
    c_wake: cover property (i_wakeup_rst);
    c_bad: cover property (o_ratio.out_code_bad);
endmodule : clk_ctrl_chk

bind hf_clock_pll_and_slow_osc_control clk_ctrl_chk clk_ctrl_chk_i (.*);

/* dv/hf_clock_pll_and_slow_osc_control_tb_top.sv */
// Self-checking bench for the clock control block over classic Wishbone.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
module hf_clock_pll_and_slow_osc_control_tb_top;
    import clk_ctrl_pkg::*;
    logic i_clock = 1'b0, i_rst = 1'b1, i_wakeup_rst = 1'b0;
    wb_req_s i_wb_req = '0;
    osc_status_s i_osc_status = '0;
    logic o_wb_ack, o_crystal_osc_en;
    logic [31:0] o_wb_dat, rd;
    loop_ctrl_s o_loop_ctrl;
    pll_ref_e o_pll_ref;
    hf_src_e o_hf_src;
    slow_osc_ctrl_s o_slow_osc_ctrl;
    ratio_s o_ratio;
    int n_fail = 0, checks = 0;
    hf_clock_pll_and_slow_osc_control hf_clock_pll_and_slow_osc_control_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_wakeup_rst(i_wakeup_rst),
        .i_wb_req(i_wb_req), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
        .i_osc_status(i_osc_status), .o_crystal_osc_en(o_crystal_osc_en),
        .o_loop_ctrl(o_loop_ctrl), .o_pll_ref(o_pll_ref),
        .o_hf_src(o_hf_src), .o_slow_osc_ctrl(o_slow_osc_ctrl),
        .o_ratio(o_ratio));
    initial forever #5 i_clock = ~i_clock;
    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Ack and read data are taken at the rising edge at which ack stands
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge i_clock);
        i_wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do @(posedge i_clock); while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb_req <= '0;
    endtask : wb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic t_reset();
        rchk(8'h04, 32'h4000_0000);
        rchk(8'h08, 32'h0006_0df1);
        rchk(8'h0c, 32'h0000_0100);
        rchk(8'h10, 32'h4010_0004);
        rchk(8'h20, 32'h0000_0000);
        chk({30'h0, o_hf_src}, {30'h0, HF_SRC_FAST_RING});
        chk({30'h0, o_pll_ref}, {30'h0, REF_CRYSTAL});
        // Loop fields: ref div, mult, out div, bypass, final div and bypass
        chk(32'(o_loop_ctrl), 32'h0001_7f81);
        chk(32'(o_slow_osc_ctrl), 32'({6'h04, 5'h10, 1'h1}));
    endtask : t_reset
    task automatic t_status();
        i_osc_status <= 3'b111;
        repeat (3) @(posedge i_clock);
        wb(1'b1, 8'h04, 32'h0000_0000);
        chk({31'h0, o_crystal_osc_en}, 32'h0);
        rchk(8'h04, 32'h8000_0000);
        wb(1'b1, 8'h04, 32'h4000_0000);
        chk({31'h0, o_crystal_osc_en}, 32'h1);
        rchk(8'h04, 32'hc000_0000);
        rchk(8'h08, 32'h8006_0df1);
        rchk(8'h10, 32'hc010_0004);
    endtask : t_status
    task automatic t_ratio();
        for (int q = 0; q < 4; q++) begin
            wb(1'b1, 8'h08, 32'h0007_03f3 | (32'(q) << 10));
            @(negedge i_clock);
            chk(32'(o_ratio.ref_ratio), 32'h4);
            chk(32'(o_ratio.mult_ratio), 32'h80);
            chk(32'(o_ratio.out_ratio), q == 0 ? 32'h0 : 32'h1 << q);
            chk(32'(o_ratio.out_code_bad), 32'(q == 0));
            chk(32'(o_ratio.hf_from_crystal), 32'h1);
            chk({30'h0, o_hf_src}, {30'h0, HF_SRC_PLL});
        end
        wb(1'b1, 8'h08, 32'h0005_0ff3);
        @(negedge i_clock);
        chk({30'h0, o_pll_ref}, {30'h0, REF_FAST_RING});
        chk(32'(o_ratio.hf_from_crystal), 32'h0);
        rchk(8'h08, 32'h8005_0ff3);
    endtask : t_ratio
    task automatic t_final();
        wb(1'b1, 8'h0c, 32'h0000_003f);
        @(negedge i_clock);
        chk(32'(o_ratio.final_ratio), 32'h80);
        wb(1'b1, 8'h0c, 32'h0000_0105);
        @(negedge i_clock);
        chk(32'(o_ratio.final_ratio), 32'h1);
    endtask : t_final
    // Legal setup: 16 MHz crystal halved, VCO 512 MHz, output 128 MHz
    task automatic t_lock();
        @(posedge i_clock);
        i_osc_status <= 3'b101;
        wb(1'b1, 8'h08, 32'h0002_09f1);
        rchk(8'h08, 32'h0002_09f1);
        chk(32'(o_loop_ctrl), 32'h0001_7e0b);
        i_osc_status <= 3'b111;
        repeat (10000) @(posedge i_clock);
        rchk(8'h08, 32'h8002_09f1);
        wb(1'b1, 8'h08, 32'h0003_09f1);
        @(negedge i_clock);
        chk({30'h0, o_hf_src}, {30'h0, HF_SRC_PLL});
        wb(1'b1, 8'h08, 32'h0002_09f1); // back to fast ring first
        @(negedge i_clock);
        chk({30'h0, o_hf_src}, {30'h0, HF_SRC_FAST_RING});
        wb(1'b1, 8'h08, 32'h0006_09f1);
        chk(32'(o_loop_ctrl.bypass), 32'h1);
    endtask : t_lock
    task automatic t_wake();
        wb(1'b1, 8'h04, 32'h0000_0000);
        wb(1'b1, 8'h08, 32'h0007_0df1);
        wb(1'b1, 8'h10, 32'h4010_003f);
        @(posedge i_clock);
        i_wakeup_rst <= 1'b1;
        @(posedge i_clock);
        i_wakeup_rst <= 1'b0;
        rchk(8'h08, 32'h8006_0df1);
        rchk(8'h04, 32'hc000_0000);
        rchk(8'h0c, 32'h0000_0100);
        rchk(8'h10, 32'hc010_003f);
        chk(32'(o_loop_ctrl), 32'h0001_7f81);
        chk(32'(o_slow_osc_ctrl), 32'({6'h3f, 5'h10, 1'h1}));
        chk({30'h0, o_hf_src}, {30'h0, HF_SRC_FAST_RING});
    endtask : t_wake
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        t_status();
        t_ratio();
        t_final();
        t_lock();
        t_wake();
        conclude();
    end
    // About ten thousand cycles, nearly all of them the lock wait
    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        conclude();
    end
endmodule : hf_clock_pll_and_slow_osc_control_tb_top
